/* rtl/dcp_cpu_datapath.sv */
// Datapath: multiplier, ALU, shifter, address units, register file, bus slave.
//
// Overview of operation
// - One-cycle multiply, integer or float.
// - Float multiply: 32-bit inputs, 40-bit product.
// - Integer multiply: 24-bit inputs, 32-bit product.
// - Parallel multiply and ALU in one cycle.
// - ALU finishes int, logic, float in one cycle.
// - Integer/float conversions each in one cycle.
// - ALU results only 32-bit int or 40-bit float.
// - Barrel shift up to 32 bits, one cycle.
// - Two memory and two register operands per cycle.
// - Two address units give two addresses.
// - Address units never stall multiplier or ALU.
// - Displacement, index, circular, bit-reversed addressing.
// - Register file of 28 multiport registers.
// - Every register is a general-purpose operand.
// - Auxiliary registers are pointers and integer registers.
// - Other registers serve addressing, stack and status.
// - Integer ops keep upper eight bits unchanged.
// - Loading flag word replaces it bit for bit.
// - Push preincrements, pop postdecrements stack pointer.
// - Direct addressing: page pointer low byte selects page.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module dcp_cpu_datapath
(
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire dcp_pkg::dcp_issue_s issue,
  input  wire logic [31:0]        memOpA,
  input  wire logic [31:0]        memOpB,
  output logic [39:0]             mulResult,
  output logic                    mulValid,
  output logic [39:0]             aluResult,
  output logic                    aluValid,
  output logic [23:0]             memAddr0,
  output logic [23:0]             memAddr1,
  output logic                    addrValid0,
  output logic                    addrValid1,
  output logic [23:0]             stackAddr,
  output logic [31:0]             stackData,
  output logic                    stackWrite,
  output logic                    stackRead,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  output logic [1:0]              s_axi_bresp,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  input  wire logic [7:0]         s_axi_araddr,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp
);
  import dcp_pkg::*;

  logic [39:0] rf [NREG];
  logic [39:0] regOpA, regOpB, mulRes, aluRes, fA, fB, bF;
  logic [33:0] mA, mB, sA, sB, sum;
  logic signed [47:0] intProd;
  logic signed [49:0] fltProd;
  logic signed [9:0]  eA, eB;
  logic [31:0] r32;
  logic [32:0] wide;
  logic [6:0]  shAmt;
  logic [3:0]  flags;
  logic        aluFlt, aluWr, flagWr, mulWr;
  logic [4:0]  aluDst;
  dcp_agres_s  ag0, ag1;
  logic [7:0]  awAddr_reg;
  logic [31:0] wData_reg, axiWord;
  logic [3:0]  wStrb_reg;
  logic        awHave_reg, wHave_reg, doWrite, axiWr;
  logic        awHaveNext, wHaveNext, bValidNext, rValidNext;

  // Reads a register, unused indices read as zero.
  function automatic logic [39:0] rfRd(input logic [4:0] i);
    return (i < 5'(NREG)) ? rf[i] : 40'h00_0000_0000;
  endfunction

  // Low word of a register, as seen over the register bus.
  function automatic logic [31:0] rfLo(input logic [4:0] i);
    logic [39:0] w;
    w = rfRd(i);
    return w[31:0];
  endfunction

  // Widens a 32-bit short float to the 40-bit float layout.
  function automatic logic [39:0] fExt(input logic [31:0] s);
    return {s[31:24], s[23], s[22:0], 8'h00};
  endfunction

  // Signed mantissa with two sign bits, binary point above bit 30.
  function automatic logic [33:0] fMant(input logic [39:0] f);
    if (f[39:32] == EXP_ZERO)
      return 34'h0_0000_0000;
    return {f[31], f[31], ~f[31], f[30:0]};
  endfunction

  // Normalises a mantissa and exponent into the 40-bit float layout.
  function automatic logic [39:0] fNorm(input logic [33:0] m, input logic signed [9:0] e);
    logic [33:0]       t;
    logic signed [9:0] x;
    t = m;
    x = e;
    if (t[33] != t[32])
    begin
      t = {t[33], t[33:1]};
      x = x + 10'sd1;
    end
    for (int i = 0; i < 32; i++)
      if (t[32] == t[31])
      begin
        t = t << 1;
        x = x - 10'sd1;
      end
    if (m == 34'h0_0000_0000 || x < -10'sd127)
      return {EXP_ZERO, 32'h0000_0000};
    if (x > 10'sd127)
      return {EXP_MAX, m[33], {31{~m[33]}}};
    return {x[7:0], t[32], t[30:0]};
  endfunction

  // Sign-extended exponent of a 40-bit float.
  function automatic logic signed [9:0] fExp(input logic [39:0] f);
    return {{2{f[39]}}, f[39:32]};
  endfunction

  // Reverses the bit order of a 24-bit address.
  function automatic logic [23:0] rev24(input logic [23:0] a);
    for (int i = 0; i < 24; i++)
      rev24[i] = a[23 - i];
  endfunction

  // One address unit: output address and updated pointer.
  function automatic dcp_agres_s agen(input dcp_agen_s c, input logic [31:0] ar,
                                      input logic [31:0] ix0, input logic [31:0] ix1,
                                      input logic [31:0] blk, input logic [31:0] pg);
    logic [31:0] sx, msk, off, nx;
    sx  = {{16{c.disp[15]}}, c.disp};
    msk = blk;
    for (int i = 0; i < 5; i++)
      msk = msk | (msk >> (1 << i));
    off = (ar & msk) + sx;
    if (off >= blk)
      off = off - blk;
    nx = ar;
    unique case (c.mode)
      AM_DISP: nx = ar + sx;
      AM_IDX0: nx = ar + ix0;
      AM_IDX1: nx = ar + ix1;
      AM_CIRC: nx = (ar & ~msk) | off;
      AM_BREV: nx = {ar[31:24], rev24(rev24(ar[23:0]) + rev24(ix0[23:0]))};
      default: nx = ar;
    endcase
    agen.next = nx;
    if (c.mode == AM_DIR)
      agen.addr = {pg[7:0], c.disp};
    else if (c.mode == AM_CIRC || c.mode == AM_BREV)
      agen.addr = ar[23:0];
    else
      agen.addr = nx[23:0];
  endfunction

  // Keeps the upper eight bits of an extended register on integer writes.
  function automatic logic [39:0] wrMerge(input logic [39:0] old, input logic [39:0] v,
                                          input logic flt, input int idx);
    if (idx >= int'(RI_AUX))
      return {8'h00, v[31:0]};
    if (flt)
      return v;
    return {old[39:32], v[31:0]};
  endfunction

  // Register operand buses and the two address units.
  // A process, not an assign, so that a register write alone refreshes the operands.
  always_comb
  begin
    regOpA = rfRd(issue.srcA);
    regOpB = rfRd(issue.srcB);
  end
  assign ag0 = agen(issue.ag0, rf[RI_AUX + 5'(issue.ag0.ar)][31:0], rf[RI_IX0][31:0],
                    rf[RI_IX1][31:0], rf[RI_BLK][31:0], rf[RI_PG][31:0]);
  assign ag1 = agen(issue.ag1, rf[RI_AUX + 5'(issue.ag1.ar)][31:0], rf[RI_IX0][31:0],
                    rf[RI_IX1][31:0], rf[RI_BLK][31:0], rf[RI_PG][31:0]);

  // Multiplier: memory operand A times register operand A.
  always_comb
  begin
    fA = fExt(memOpA);
    fB = {regOpA[39:8], 8'h00};
    mA = fMant(fA);
    mB = fMant(fB);
    intProd = $signed(memOpA[23:0]) * $signed(regOpA[23:0]);
    fltProd = $signed(mA[32:8]) * $signed(mB[32:8]);
    if (issue.mulOp == MUL_FLT)
      mulRes = fNorm(fltProd[49:16], fExp(fA) + fExp(fB) + 10'sd1);
    else
      mulRes = {8'h00, intProd[31:0]};
  end

  // ALU: register operand B against memory operand B.
  always_comb
  begin
    bF = fExt(memOpB);
    sA = fMant(regOpB);
    sB = fMant(bF);
    if (issue.aluOp == OP_SUBF)
      sB = -sB;
    eA = fExp(regOpB);
    eB = fExp(bF);
    if (eA >= eB)
      sB = 34'($signed(sB) >>> (eA - eB));
    else
      sA = 34'($signed(sA) >>> (eB - eA));
    sum = sA + sB;
    shAmt = memOpB[6:0];
    wide = 33'h0_0000_0000;
    r32 = 32'h0000_0000;
    aluRes = 40'h00_0000_0000;
    aluFlt = 1'b0;
    unique case (issue.aluOp)
      OP_ADDI: wide = {1'b0, regOpB[31:0]} + {1'b0, memOpB};
      OP_SUBI: wide = {1'b0, regOpB[31:0]} - {1'b0, memOpB};
      OP_AND:  r32 = regOpB[31:0] & memOpB;
      OP_OR:   r32 = regOpB[31:0] | memOpB;
      OP_XOR:  r32 = regOpB[31:0] ^ memOpB;
      OP_LSH:  r32 = shAmt[6] ? regOpB[31:0] >> (-shAmt) : regOpB[31:0] << shAmt;
      OP_ASH:  r32 = shAmt[6] ? 32'($signed(regOpB[31:0]) >>> (-shAmt))
                              : regOpB[31:0] << shAmt;
      OP_LDI, OP_LDST: r32 = memOpB;
      OP_FIX:
      begin
        if (regOpB[39:32] == EXP_ZERO)
          r32 = 32'h0000_0000;
        else if (eA > 10'sd30)
          r32 = regOpB[31] ? 32'h8000_0000 : 32'h7FFF_FFFF;
        else
          r32 = 32'($signed(fMant(regOpB)) >>> (10'sd31 - eA));
      end
      default: r32 = 32'h0000_0000;
    endcase
    if (issue.aluOp == OP_ADDI || issue.aluOp == OP_SUBI)
      r32 = wide[31:0];
    if (issue.aluOp == OP_ADDF || issue.aluOp == OP_SUBF)
    begin
      aluRes = fNorm(sum, (eA >= eB) ? eA : eB);
      aluFlt = 1'b1;
    end
    else if (issue.aluOp == OP_FLT)
    begin
      aluRes = fNorm({{2{memOpB[31]}}, memOpB}, 10'sd31);
      aluFlt = 1'b1;
    end
    else
      aluRes = {8'h00, r32};
    flags[FL_N] = aluFlt ? aluRes[31] : r32[31];
    flags[FL_Z] = aluFlt ? (aluRes[39:32] == EXP_ZERO) : (r32 == 32'h0000_0000);
    flags[FL_C] = (issue.aluOp == OP_ADDI || issue.aluOp == OP_SUBI) & wide[32];
    flags[FL_V] = (issue.aluOp == OP_ADDI) ? (regOpB[31] == memOpB[31]) & (r32[31] != memOpB[31])
                : (issue.aluOp == OP_SUBI) ? (regOpB[31] != memOpB[31]) & (r32[31] == memOpB[31])
                : 1'b0;
  end

  // Write enables and the effective ALU destination.
  assign aluWr  = issue.valid && issue.aluOp != OP_NOP && issue.aluOp != OP_PUSH
                  && issue.aluOp != OP_POP;
  assign aluDst = (issue.aluOp == OP_LDST) ? RI_FLG : issue.aluDst;
  assign mulWr  = issue.valid && issue.mulOp != MUL_NONE;
  assign flagWr = aluWr && aluDst != RI_FLG;

  // Register file: each entry takes its own write, ALU first, bus last.
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < NREG; i++)
      if (reset)
        rf[i] <= 40'h00_0000_0000;
      else if (aluWr && int'(aluDst) == i)
        rf[i] <= wrMerge(rf[i], aluRes, aluFlt, i);
      else if (mulWr && int'(issue.mulDst) == i)
        rf[i] <= wrMerge(rf[i], mulRes, issue.mulOp == MUL_FLT, i);
      else if (issue.valid && issue.ag0.upd && int'(RI_AUX) + int'(issue.ag0.ar) == i)
        rf[i] <= {8'h00, ag0.next};
      else if (issue.valid && issue.ag1.upd && int'(RI_AUX) + int'(issue.ag1.ar) == i)
        rf[i] <= {8'h00, ag1.next};
      else if (issue.valid && issue.aluOp == OP_PUSH && i == int'(RI_STK))
        rf[i] <= {8'h00, rf[i][31:0] + 32'h0000_0001};
      else if (issue.valid && issue.aluOp == OP_POP && i == int'(RI_STK))
        rf[i] <= {8'h00, rf[i][31:0] - 32'h0000_0001};
      else if (flagWr && i == int'(RI_FLG))
        rf[i] <= {rf[i][39:4], flags};
      else if (axiWr && int'(awAddr_reg[6:2]) == i)
        rf[i] <= wrMerge(rf[i], {8'h00, axiWord}, 1'b0, i);
  end

  // Result, address and stack outputs, one cycle after issue.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      mulResult  <= 40'h00_0000_0000;
      mulValid   <= 1'b0;
      aluResult  <= 40'h00_0000_0000;
      aluValid   <= 1'b0;
      memAddr0   <= 24'h00_0000;
      memAddr1   <= 24'h00_0000;
      addrValid0 <= 1'b0;
      addrValid1 <= 1'b0;
      stackAddr  <= 24'h00_0000;
      stackData  <= 32'h0000_0000;
      stackWrite <= 1'b0;
      stackRead  <= 1'b0;
    end
    else
    begin
      mulResult  <= mulRes;
      mulValid   <= mulWr;
      aluResult  <= aluRes;
      aluValid   <= aluWr;
      memAddr0   <= ag0.addr;
      memAddr1   <= ag1.addr;
      addrValid0 <= issue.valid && issue.ag0.mode != AM_NONE;
      addrValid1 <= issue.valid && issue.ag1.mode != AM_NONE;
      stackWrite <= issue.valid && issue.aluOp == OP_PUSH;
      stackRead  <= issue.valid && issue.aluOp == OP_POP;
      stackData  <= regOpB[31:0];
      stackAddr  <= (issue.aluOp == OP_PUSH) ? 24'(rf[RI_STK][23:0] + 24'h00_0001)
                                              : rf[RI_STK][23:0];
    end
  end

  // Bus write path: address and data taken in either order.
  assign doWrite    = awHave_reg && wHave_reg && !s_axi_bvalid;
  assign axiWr      = doWrite && awAddr_reg < REG_SPAN;
  assign awHaveNext = (awHave_reg || (s_axi_awvalid && s_axi_awready)) && !doWrite;
  assign wHaveNext  = (wHave_reg || (s_axi_wvalid && s_axi_wready)) && !doWrite;
  assign bValidNext = doWrite || (s_axi_bvalid && !s_axi_bready);
  always_comb
  begin
    axiWord = rfLo(awAddr_reg[6:2]);
    for (int b = 0; b < 4; b++)
      if (wStrb_reg[b])
        axiWord[8 * b +: 8] = wData_reg[8 * b +: 8];
  end

  // Bus write handshake registers.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      awHave_reg    <= 1'b0;
      wHave_reg     <= 1'b0;
      awAddr_reg    <= 8'h00;
      wData_reg     <= 32'h0000_0000;
      wStrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
    end
    else
    begin
      awHave_reg    <= awHaveNext;
      wHave_reg     <= wHaveNext;
      s_axi_awready <= !awHaveNext && !bValidNext;
      s_axi_wready  <= !wHaveNext && !bValidNext;
      s_axi_bvalid  <= bValidNext;
      if (s_axi_awvalid && s_axi_awready)
        awAddr_reg <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite)
        s_axi_bresp <= (awAddr_reg < REG_SPAN) ? RESP_OK : RESP_ERR;
    end
  end

  // Bus read path: one read at a time, answered the cycle after the take.
  assign rValidNext = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end
    else
    begin
      s_axi_arready <= !rValidNext;
      s_axi_rvalid  <= rValidNext;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rdata <= (s_axi_araddr < REG_SPAN) ? rfLo(s_axi_araddr[6:2]) : 32'h0000_0000;
        s_axi_rresp <= (s_axi_araddr < REG_SPAN) ? RESP_OK : RESP_ERR;
      end
    end
  end

  // Checks on the datapath, sampled on the processor clock.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_push;
    issue.valid && issue.aluOp == OP_PUSH;
  endsequence
  sequence s_stk_up;
    ##1 rf[RI_STK][31:0] == $past(rf[RI_STK][31:0]) + 32'h0000_0001;
  endsequence

  property p_mul_cycle;
    mulWr |=> mulValid && mulResult == $past(mulRes);
  endproperty
  a_mul_cycle: assert property (p_mul_cycle) else $error("multiply late");

  property p_int_mul;
    issue.valid && issue.mulOp == MUL_INT
      |=> mulResult[31:0] == 32'($signed($past(memOpA[23:0])) * $signed($past(regOpA[23:0])));
  endproperty
  a_int_mul: assert property (p_int_mul) else $error("integer product wrong");

  property p_parallel;
    mulWr && aluWr |=> mulValid && aluValid;
  endproperty
  a_parallel: assert property (p_parallel) else $error("parallel op split");

  property p_load_status;
    issue.valid && issue.aluOp == OP_LDST |=> rf[RI_FLG][31:0] == $past(memOpB);
  endproperty
  a_load_status: assert property (p_load_status) else $error("status load altered");

  property p_upper_kept;
    aluWr && !aluFlt && aluDst < RI_AUX
      |=> rf[$past(aluDst)][39:32] == $past(rf[aluDst][39:32]);
  endproperty
  a_upper_kept: assert property (p_upper_kept) else $error("upper bits changed");

  property p_push;
    s_push |-> s_stk_up ##0 (stackWrite && stackAddr == rf[RI_STK][23:0]);
  endproperty
  a_push: assert property (p_push) else $error("push pointer wrong");

  property p_dual_write;
    aluWr && mulWr && aluDst != issue.mulDst && issue.mulOp == MUL_INT
      && aluDst < 5'(NREG) && issue.mulDst < 5'(NREG)
      |=> rf[$past(issue.mulDst)][31:0] == mulResult[31:0]
          && rf[$past(aluDst)][31:0] == aluResult[31:0];
  endproperty
  a_dual_write: assert property (p_dual_write) else $error("parallel write lost");

  property p_direct;
    issue.valid && issue.ag0.mode == AM_DIR
      |=> addrValid0 && memAddr0 == {$past(rf[RI_PG][7:0]), $past(issue.ag0.disp)};
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");
endmodule

/* rtl/dcp_pkg.sv */
// Shared constants and carrier types of the signal processor datapath.
package dcp_pkg;
  // Register file size and the indices of the special registers.
  localparam int         NREG  = 28;
  localparam logic [4:0] RI_AUX = 5'h08;
  localparam logic [4:0] RI_PG  = 5'h10;
  localparam logic [4:0] RI_IX0 = 5'h11;
  localparam logic [4:0] RI_IX1 = 5'h12;
  localparam logic [4:0] RI_BLK = 5'h13;
  localparam logic [4:0] RI_STK = 5'h14;
  localparam logic [4:0] RI_FLG = 5'h15;
  // Multiplier operations.
  localparam logic [1:0] MUL_NONE = 2'h0;
  localparam logic [1:0] MUL_INT  = 2'h1;
  localparam logic [1:0] MUL_FLT  = 2'h2;
  // ALU operations.
  localparam logic [3:0] OP_NOP  = 4'h0;
  localparam logic [3:0] OP_ADDI = 4'h1;
  localparam logic [3:0] OP_SUBI = 4'h2;
  localparam logic [3:0] OP_AND  = 4'h3;
  localparam logic [3:0] OP_OR   = 4'h4;
  localparam logic [3:0] OP_XOR  = 4'h5;
  localparam logic [3:0] OP_ADDF = 4'h6;
  localparam logic [3:0] OP_SUBF = 4'h7;
  localparam logic [3:0] OP_FLT  = 4'h8;
  localparam logic [3:0] OP_FIX  = 4'h9;
  localparam logic [3:0] OP_LSH  = 4'hA;
  localparam logic [3:0] OP_ASH  = 4'hB;
  localparam logic [3:0] OP_LDI  = 4'hC;
  localparam logic [3:0] OP_LDST = 4'hD;
  localparam logic [3:0] OP_PUSH = 4'hE;
  localparam logic [3:0] OP_POP  = 4'hF;
  // Address unit modes.
  localparam logic [2:0] AM_NONE = 3'h0;
  localparam logic [2:0] AM_DISP = 3'h1;
  localparam logic [2:0] AM_IDX0 = 3'h2;
  localparam logic [2:0] AM_IDX1 = 3'h3;
  localparam logic [2:0] AM_CIRC = 3'h4;
  localparam logic [2:0] AM_BREV = 3'h5;
  localparam logic [2:0] AM_DIR  = 3'h6;
  // Flag positions in the condition flag word and float constants.
  localparam int         FL_C     = 0;
  localparam int         FL_V     = 1;
  localparam int         FL_Z     = 2;
  localparam int         FL_N     = 3;
  localparam logic [7:0] EXP_ZERO = 8'h80;
  localparam logic [7:0] EXP_MAX  = 8'h7F;
  // Register bus map: one word per register from offset zero.
  localparam logic [7:0] REG_SPAN = 8'h70;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef struct packed {
    logic [2:0]  mode;
    logic [2:0]  ar;
    logic        upd;
    logic [15:0] disp;
  } dcp_agen_s;

  typedef struct packed {
    logic [23:0] addr;
    logic [31:0] next;
  } dcp_agres_s;

  typedef struct packed {
    logic       valid;
    logic [1:0] mulOp;
    logic [4:0] mulDst;
    logic [3:0] aluOp;
    logic [4:0] aluDst;
    logic [4:0] srcA;
    logic [4:0] srcB;
    dcp_agen_s  ag0;
    dcp_agen_s  ag1;
  } dcp_issue_s;
endpackage

/* tb/dcp_mem_model.sv */
// Model of the memory operand buses that feed the datapath.
`timescale 1ns/1ps
module dcp_mem_model
(
  input  wire logic        take,
  input  wire logic [31:0] valA,
  input  wire logic [31:0] valB,
  output logic [31:0]      memOpA,
  output logic [31:0]      memOpB
);
  // Outside an issue the buses show the inverse, so a stale operand is never reused.
  assign memOpA = take ? valA : ~valA;
  assign memOpB = take ? valB : ~valB;
endmodule

/* tb/tb_dcp_cpu_datapath.sv */
// Self-checking testbench of the signal processor datapath.
`timescale 1ns/1ps
module tb_dcp_cpu_datapath;
  import dcp_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  dcp_issue_s  issue = '0;
  logic [31:0] valA = '0, valB = '0, memOpA, memOpB, stackData;
  logic [39:0] mulResult, aluResult;
  logic [23:0] memAddr0, memAddr1, stackAddr;
  logic        mulValid, aluValid, addrValid0, addrValid1, stackWrite, stackRead;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          fail_count = 0;
  int          n_checks = 0;
  dcp_issue_s  x;

  // The clock runs at 10 MHz.
  always #50 ref_clk = ~ref_clk;

  dcp_cpu_datapath dcp_cpu_datapath_i (.ref_clk, .reset, .issue, .memOpA, .memOpB,
    .mulResult, .mulValid, .aluResult, .aluValid, .memAddr0, .memAddr1, .addrValid0,
    .addrValid1, .stackAddr, .stackData, .stackWrite, .stackRead, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp);
  dcp_mem_model dcp_mem_model_i (.take(issue.valid), .valA, .valB, .memOpA, .memOpB);

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      fail_count++;
    end
  endtask

  // Counts a used-up wait as a mismatch and closes.
  task automatic hang(input int n);
    if (n >= 50)
    begin
      $display("wrong value at %0t: no bus answer", $time);
      fail_count++;
      close_out();
    end
  endtask

  // Register write: address and data offered together, each released once taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    hang(n);
    chk(s_axi_bresp, r);
  endtask

  // Register read with expected data and response.
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    hang(n);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
  endtask

  // Issues one operation for one cycle; outputs are settled on return.
  task automatic run(input dcp_issue_s i, input logic [31:0] a, input logic [31:0] b);
    @(posedge ref_clk);
    issue <= i;
    valA <= a;
    valB <= b;
    @(posedge ref_clk);
    issue <= '0;
    #1;
  endtask

  function automatic dcp_issue_s mk(logic [1:0] m, logic [4:0] md, logic [3:0] o,
                                    logic [4:0] od, logic [4:0] sa, logic [4:0] sb);
    mk = '{1'b1, m, md, o, od, sa, sb, '0, '0};
  endfunction

  // Main sequence of tests.
  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < NREG; i++)
      axi_rd(8'(4 * i), 32'h0, RESP_OK);
    $display("test reset done");
    axi_wr(8'h04, 32'h7, RESP_OK);
    axi_wr(8'h0C, 32'h3, RESP_OK);
    run(mk(MUL_INT, 5'h04, OP_ADDI, 5'h02, 5'h03, 5'h01), 32'h5, 32'h5);
    chk({mulValid, aluValid}, 40'h3);
    chk(mulResult, 40'hF);
    chk(aluResult, 40'hC);
    axi_rd(8'h08, 32'hC, RESP_OK);
    axi_rd(8'h10, 32'hF, RESP_OK);
    run(mk(MUL_NONE, 5'h0, OP_LSH, 5'h05, 5'h0, 5'h01), 32'h0, 32'h4);
    chk(aluResult, 40'h70);
    run(mk(MUL_NONE, 5'h0, OP_LDST, RI_FLG, 5'h0, 5'h0), 32'h0, 32'hF);
    axi_rd(8'h54, 32'hF, RESP_OK);
    $display("test arithmetic done");
    axi_wr(8'h50, 32'h10, RESP_OK);
    run(mk(MUL_NONE, 5'h0, OP_PUSH, 5'h0, 5'h0, 5'h01), 32'h0, 32'h0);
    chk({stackWrite, stackAddr}, {1'b1, 24'h11});
    chk(stackData, 40'h7);
    axi_rd(8'h50, 32'h11, RESP_OK);
    run(mk(MUL_NONE, 5'h0, OP_POP, 5'h01, 5'h0, 5'h0), 32'h0, 32'h0);
    chk({stackRead, stackAddr}, {1'b1, 24'h11});
    axi_rd(8'h50, 32'h10, RESP_OK);
    $display("test stack done");
    run(mk(MUL_NONE, 5'h0, OP_FLT, 5'h06, 5'h0, 5'h0), 32'h0, 32'h2);
    chk(aluResult, 40'h01_0000_0000);
    run(mk(MUL_FLT, 5'h07, OP_ADDF, 5'h03, 5'h06, 5'h06), 32'h0100_0000, 32'h0);
    chk(mulResult, 40'h02_0000_0000);
    chk(aluResult, 40'h01_4000_0000);
    run(mk(MUL_NONE, 5'h0, OP_ADDI, 5'h06, 5'h0, 5'h06), 32'h0, 32'h5);
    run(mk(MUL_NONE, 5'h0, OP_FIX, 5'h0, 5'h0, 5'h06), 32'h0, 32'h0);
    chk(aluResult, 40'h2);
    $display("test float done");
    axi_wr(8'h20, 32'h100, RESP_OK);
    axi_wr(8'h24, 32'h200, RESP_OK);
    axi_wr(8'h44, 32'h2, RESP_OK);
    axi_wr(8'h40, 32'h12, RESP_OK);
    x = mk(MUL_NONE, 5'h0, OP_ADDI, 5'h02, 5'h0, 5'h01);
    x.ag0 = '{AM_DISP, 3'h0, 1'b0, 16'h4};
    x.ag1 = '{AM_IDX0, 3'h1, 1'b0, 16'h0};
    run(x, 32'h0, 32'h1);
    chk({addrValid0, addrValid1, aluValid}, 40'h7);
    chk(memAddr0, 40'h104);
    chk(memAddr1, 40'h202);
    x.ag0 = '{AM_DIR, 3'h0, 1'b0, 16'h34};
    run(x, 32'h0, 32'h1);
    chk(memAddr0, 40'h120034);
    axi_wr(8'h44, 32'h100, RESP_OK);
    x.ag0 = '{AM_BREV, 3'h0, 1'b1, 16'h0};
    run(x, 32'h0, 32'h1);
    chk(memAddr0, 40'h100);
    axi_rd(8'h20, 32'h80, RESP_OK);
    axi_wr(8'h70, 32'h5, RESP_ERR);
    axi_rd(8'h70, 32'h0, RESP_ERR);
    $display("test address done");
    close_out();
  end
endmodule
